// *** core/cmf_cfg.svh ***
/*
 Register offsets, field positions, reset values and timing counts of the CAN mode and
 filter control core. Assumes inclusion by bare name from the core file only.
*/
`ifndef CMF_CFG_SVH
`define CMF_CFG_SVH
// Register byte offsets on the AXI4-Lite bus
`define CMF_OFF_MODCTL     12'h000
`define CMF_OFF_FLTCTL     12'h004
`define CMF_OFF_TSTAMP     12'h008
// Module control word field positions
`define CMF_ABORT_BIT      27
`define CMF_REQ_HI         26
`define CMF_REQ_LO         24
`define CMF_STAT_HI        23
`define CMF_STAT_LO        21
`define CMF_CAP_BIT        20
`define CMF_ON_BIT         15
`define CMF_BUSY_BIT       11
// Filter control word: byte lane per filter, filter 16 in byte 0
`define CMF_FLT_EN_POS     7
`define CMF_FLT_MSK_HI     6
`define CMF_FLT_MSK_LO     5
`define CMF_FLT_FIFO_HI    4
`define CMF_FLT_FIFO_LO    0
// Reset values
`define CMF_MODE_RESET     3'h4
`define CMF_MODCTL_RESET   32'h0480_0000
`define CMF_FLTCTL_RESET   32'h0000_0000
// Mode change settle time and clock rate
`define CMF_MODE_SETTLE_NS 100
`define CMF_CLK_PERIOD_NS  20
`define CMF_MODE_CYCLES    ((`CMF_MODE_SETTLE_NS + `CMF_CLK_PERIOD_NS - 1) / `CMF_CLK_PERIOD_NS)
`endif

// *** core/cmf_pkg.sv ***
/*
 Types of the CAN mode and filter control core. Assumes cmf_cfg.svh is on the include path.
*/
package cmf_pkg;
   // Operating mode codes, shared by request and status fields
   typedef enum logic [2:0] {
      CMF_MODE_NORMAL   = 3'h0,
      CMF_MODE_DISABLE  = 3'h1,
      CMF_MODE_LOOPBACK = 3'h2,
      CMF_MODE_LISTEN   = 3'h3,
      CMF_MODE_CONFIG   = 3'h4,
      CMF_MODE_LISTALL  = 3'h7
   } cmf_mode_e;

   // One filter's configuration as seen by the acceptance logic
   typedef struct packed {
      logic       enable;
      logic [1:0] mask_sel;
      logic [4:0] fifo_sel;
   } cmf_filter_s;

   // Events from the protocol engine
   typedef struct packed {
      logic tx_pending;
      logic xact_active;
      logic rx_valid;
   } cmf_engine_s;
endpackage

// *** core/cmf_core.sv ***
/*
 CAN mode and filter control core: AXI4-Lite slave holding the module control word, the
 filter control word for filters 16 to 19 and the latest receive time stamp.
 Assumes a protocol engine beside it that reports pending transmissions, an ongoing
 transaction and each valid reception, all on ref_clk_i.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cmf_cfg.svh"

// Notes on behaviour
// - Abort bit tells all transmit buffers abort
// - Hardware clears abort once nothing pending
// - Mode request decoded; reserved codes ignored
// - Read-only status shows current mode code
// - Capture enabled: store timer on reception
// - Capture disabled: timer stopped, no capture
// - On bit enables the whole controller
// - Busy stays set until disable honoured
// - Each filter has an enable bit
// - Two-bit mask select picks mask 0..3
// - Five-bit FIFO select picks FIFO 0..31
// - Filter 19 fields at bits 30-24
// - Filter 18 fields at bits 22-16
// - Filter fields writable only while disabled
module cmf_core #(
   parameter int TMR_W = 16   // Receive time stamp timer width
) (
   // Clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_i,
   // AXI4-Lite write address and data
   input  wire logic                   s_axi_awvalid,
   output      logic                   s_axi_awready,
   input  wire logic [11:0]            s_axi_awaddr,
   input  wire logic                   s_axi_wvalid,
   output      logic                   s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   // AXI4-Lite write response
   output      logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output      logic [1:0]             s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                   s_axi_arvalid,
   output      logic                   s_axi_arready,
   input  wire logic [11:0]            s_axi_araddr,
   output      logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output      logic [31:0]            s_axi_rdata,
   output      logic [1:0]             s_axi_rresp,
   // Protocol engine status
   input  wire cmf_pkg::cmf_engine_s   engine_i,
   // Controls towards the protocol engine
   output      logic                   abort_all_tx_o,
   output      logic                   module_enable_o,
   output      logic [2:0]             mode_status_o,
   output      cmf_pkg::cmf_filter_s [3:0] filter_cfg_o,
   output      logic [TMR_W-1:0]       rx_timestamp_o
);

   localparam int MODE_CYC = `CMF_MODE_CYCLES;

   // Write-lane merge, used for both control words
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Legal mode code check
   function automatic logic mode_legal(input logic [2:0] m);
      return (m != 3'h5) && (m != 3'h6);
   endfunction

   // Bus slave state
   logic        aw_q, aw_d;             // Write address held
   logic [11:0] awa_q, awa_d;
   logic        w_q, w_d;               // Write data held
   logic [31:0] wd_q, wd_d;
   logic [3:0]  ws_q, ws_d;
   logic        bv_q, bv_d;
   logic [1:0]  br_q, br_d;
   logic        rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0]  rr_q, rr_d;
   // Control state
   logic        abort_q, abort_d;       // Abort request
   logic [2:0]  req_q, req_d;           // Requested mode
   logic [2:0]  stat_q, stat_d;         // Current mode
   logic        cap_q, cap_d;           // Time stamp capture enable
   logic        on_q, on_d;             // Module on
   logic        busy_q, busy_d;         // Module busy
   logic [3:0]  mcnt_q, mcnt_d;         // Mode transition cycle count, counts up
   logic [31:0] flt_q, flt_d;           // Filter control word
   logic [TMR_W-1:0] tmr_q, tmr_d;      // Free timer
   logic [TMR_W-1:0] ts_q, ts_d;        // Captured time stamp
   logic        wr_go;                  // Write performed this cycle
   logic [31:0] modctl;                 // Module control word as read

   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready  = !w_q && !bv_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;
   assign wr_go         = aw_q && w_q && !bv_q;

   always_comb
   begin
      modctl = 32'h0;
      modctl[`CMF_ABORT_BIT] = abort_q;
      modctl[`CMF_REQ_HI:`CMF_REQ_LO] = req_q;
      modctl[`CMF_STAT_HI:`CMF_STAT_LO] = stat_q;
      modctl[`CMF_CAP_BIT] = cap_q;
      modctl[`CMF_ON_BIT] = on_q;
      modctl[`CMF_BUSY_BIT] = busy_q;
   end

   // Bus handshake: address and data latch in either order, response after both
   always_comb
   begin
      aw_d = aw_q;
      awa_d = awa_q;
      w_d = w_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_go)
      begin
         // Read-only time stamp and unmapped offsets answer with a slave error
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = (awa_q == `CMF_OFF_MODCTL || awa_q == `CMF_OFF_FLTCTL) ? 2'h0 : 2'h2;
      end
      else if (bv_q && s_axi_bready)
      begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         rv_d = 1'b1;
         rr_d = 2'h0;
         unique case (s_axi_araddr)
            `CMF_OFF_MODCTL: rd_d = modctl;
            `CMF_OFF_FLTCTL: rd_d = flt_q;
            `CMF_OFF_TSTAMP: rd_d = {{(32-TMR_W){1'b0}}, ts_q};
            default:
            begin
               rd_d = 32'h0;
               rr_d = 2'h2;
            end
         endcase
      end
      else if (rv_q && s_axi_rready)
      begin
         rv_d = 1'b0;
      end
   end

   // Module control: abort, mode, capture, on and busy
   always_comb
   begin
      logic [31:0] nv;
      nv = lane_merge(modctl, wd_q, ws_q);
      abort_d = abort_q;
      req_d = req_q;
      cap_d = cap_q;
      on_d = on_q;
      stat_d = stat_q;
      mcnt_d = mcnt_q;
      busy_d = busy_q;
      if (wr_go && awa_q == `CMF_OFF_MODCTL)
      begin
         // Abort is settable only; software cannot clear it
         if (nv[`CMF_ABORT_BIT])
         begin
            abort_d = 1'b1;
         end
         if (mode_legal(nv[`CMF_REQ_HI:`CMF_REQ_LO]))
         begin
            req_d = nv[`CMF_REQ_HI:`CMF_REQ_LO];
         end
         cap_d = nv[`CMF_CAP_BIT];
         on_d = nv[`CMF_ON_BIT];
      end
      else if (abort_q && !engine_i.tx_pending)
      begin
         abort_d = 1'b0;
      end
      // Status follows the request only after the settle count reaches MODE_CYC - 1
      if (req_q != stat_q)
      begin
         if (mcnt_q == 4'(MODE_CYC - 1))
         begin
            stat_d = req_q;
            mcnt_d = 4'h0;
         end
         else
         begin
            mcnt_d = mcnt_q + 4'h1;
         end
      end
      else
      begin
         mcnt_d = 4'h0;
      end
      // Busy while on, or while a transaction still finishes after off
      busy_d = on_q || engine_i.xact_active;
   end

   // Filter control word: each filter's fields only while it is disabled, its enable bit always
   always_comb
   begin
      logic [31:0] nv;
      nv = lane_merge(flt_q, wd_q, ws_q);
      flt_d = flt_q;
      if (wr_go && awa_q == `CMF_OFF_FLTCTL)
      begin
         for (int f = 0; f < 4; f++)
         begin
            if (!flt_q[f*8 + `CMF_FLT_EN_POS])
            begin
               flt_d[f*8 +: 8] = nv[f*8 +: 8];
            end
            else
            begin
               // Enabled filter: fields locked, only enable bit writable
               flt_d[f*8 + `CMF_FLT_EN_POS] = nv[f*8 + `CMF_FLT_EN_POS];
            end
         end
      end
   end

   // Timer runs only while capture is enabled, to save power
   always_comb
   begin
      tmr_d = cap_q ? tmr_q + 1'b1 : tmr_q;
      ts_d = ts_q;
      if (cap_q && engine_i.rx_valid)
      begin
         ts_d = tmr_q;
      end
   end

   // Filter fields exposed to the acceptance logic
   always_comb
   begin
      for (int f = 0; f < 4; f++)
      begin
         filter_cfg_o[f].enable   = flt_q[f*8 + `CMF_FLT_EN_POS];
         filter_cfg_o[f].mask_sel = flt_q[f*8 + `CMF_FLT_MSK_LO +: 2];
         filter_cfg_o[f].fifo_sel = flt_q[f*8 + `CMF_FLT_FIFO_LO +: 5];
      end
   end

   assign abort_all_tx_o  = abort_q;
   assign module_enable_o = on_q;
   assign mode_status_o   = stat_q;
   assign rx_timestamp_o  = ts_q;

   // Register all state
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         aw_q <= 1'b0;
         awa_q <= 12'h000;
         w_q <= 1'b0;
         wd_q <= 32'h0;
         ws_q <= 4'h0;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         rv_q <= 1'b0;
         rd_q <= 32'h0;
         rr_q <= 2'h0;
         abort_q <= 1'b0;
         req_q <= `CMF_MODE_RESET;
         stat_q <= `CMF_MODE_RESET;
         cap_q <= 1'b0;
         on_q <= 1'b0;
         busy_q <= 1'b0;
         mcnt_q <= 4'h0;
         flt_q <= `CMF_FLTCTL_RESET;
         tmr_q <= '0;
         ts_q <= '0;
      end
      else
      begin
         aw_q <= aw_d;
         awa_q <= awa_d;
         w_q <= w_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         abort_q <= abort_d;
         req_q <= req_d;
         stat_q <= stat_d;
         cap_q <= cap_d;
         on_q <= on_d;
         busy_q <= busy_d;
         mcnt_q <= mcnt_d;
         flt_q <= flt_d;
         tmr_q <= tmr_d;
         ts_q <= ts_d;
      end
   end

   // Assertions
   property p_abort_clear;
      @(posedge ref_clk_i) disable iff (rst_i)
      (abort_q && !engine_i.tx_pending && !wr_go) |=> !abort_q;
   endproperty
   a_abort_clear: assert property (p_abort_clear) else $error("abort not cleared");

   property p_abort_out;
      @(posedge ref_clk_i) disable iff (rst_i) abort_all_tx_o == abort_q;
   endproperty
   a_abort_out: assert property (p_abort_out) else $error("abort not signalled");

   property p_mode_legal;
      @(posedge ref_clk_i) disable iff (rst_i) mode_legal(req_q) && mode_legal(stat_q);
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("reserved mode code");

   property p_stat_read;
      @(posedge ref_clk_i) disable iff (rst_i) modctl[23:21] == mode_status_o;
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status field mismatch");

   property p_ts_cap;
      @(posedge ref_clk_i) disable iff (rst_i)
      (cap_q && engine_i.rx_valid) |=> ts_q == $past(tmr_q);
   endproperty
   a_ts_cap: assert property (p_ts_cap) else $error("time stamp not captured");

   property p_tmr_stop;
      @(posedge ref_clk_i) disable iff (rst_i) !cap_q |=> $stable(tmr_q) && $stable(ts_q);
   endproperty
   a_tmr_stop: assert property (p_tmr_stop) else $error("timer ran while disabled");

   property p_busy;
      @(posedge ref_clk_i) disable iff (rst_i)
      ($fell(on_q) && engine_i.xact_active) |=> busy_q;
   endproperty
   a_busy: assert property (p_busy) else $error("busy dropped early");

   property p_flt_lock;
      @(posedge ref_clk_i) disable iff (rst_i)
      flt_q[31] |=> flt_q[30:24] == $past(flt_q[30:24]);
   endproperty
   a_flt_lock: assert property (p_flt_lock) else $error("locked filter changed");

   property p_mode_settle;
      @(posedge ref_clk_i) disable iff (rst_i)
      $changed(req_q) |-> ##[1:6] stat_q == req_q;
   endproperty
   a_mode_settle: assert property (p_mode_settle) else $error("mode not reached");

   c_abort: cover property (@(posedge ref_clk_i) disable iff (rst_i) $fell(abort_q));
   c_mode: cover property (@(posedge ref_clk_i) disable iff (rst_i) $changed(stat_q));
   c_cap: cover property (@(posedge ref_clk_i) disable iff (rst_i) cap_q && engine_i.rx_valid);
endmodule

// *** tb/cmf_eng_model.sv ***
/*
 Behavioural protocol engine standing beside the mode and filter control core.
 Assumes the bench commands loads, transactions and receptions after a clock edge.
*/
`timescale 1ns/1ps
module cmf_eng_model #(
   parameter int ABORT_LAT = 12,  // Cycles the buffers need to give up a frame
   parameter int XACT_TAIL = 10   // Cycles to finish a frame after switch off
) (
   // Clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_i,
   // Controls from the core
   input  wire logic                 abort_all_tx_i,
   input  wire logic                 module_enable_i,
   // Bench commands
   input  wire logic                 tx_load_i,
   input  wire logic                 xact_start_i,
   input  wire logic                 rx_req_i,
   // Engine events towards the core
   output      cmf_pkg::cmf_engine_s engine_o
);
   logic [7:0] abort_cnt_q;  // Cycles spent aborting
   logic [7:0] tail_cnt_q;   // Cycles left of the running frame

   // Engine state, deliberately slow so the core must wait on it
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         engine_o    <= '0;
         abort_cnt_q <= 8'h00;
         tail_cnt_q  <= 8'h00;
      end
      else
      begin
         // One-cycle reception pulse
         engine_o.rx_valid <= rx_req_i;
         // Count only while abort is asked and something is pending
         abort_cnt_q <= (abort_all_tx_i && engine_o.tx_pending) ? abort_cnt_q + 8'h01 : 8'h00;
         if (tx_load_i)
            engine_o.tx_pending <= 1'b1;
         else if (abort_cnt_q == 8'(ABORT_LAT))
            engine_o.tx_pending <= 1'b0;
         // A frame in flight is never cut short by switch off
         if (xact_start_i)
         begin
            engine_o.xact_active <= 1'b1;
            tail_cnt_q           <= 8'(XACT_TAIL);
         end
         else if (!module_enable_i && tail_cnt_q != 8'h00)
         begin
            tail_cnt_q           <= tail_cnt_q - 8'h01;
            engine_o.xact_active <= (tail_cnt_q != 8'h01);
         end
      end
   end
endmodule

// *** tb/tb_top.sv ***
/*
 Self-checking bench of the mode and filter control core: AXI4-Lite master tasks, a
 result queue with a monitor, and the engine model. Assumes the core answers per its note.
*/
`timescale 1ns/1ps
module tb_top;
   localparam int          TW   = 16;            // Time stamp width
   localparam logic [31:0] MCM  = 32'h0FF0_8800; // Implemented control bits
   localparam logic [31:0] ALL  = 32'hFFFF_FFFF; // Whole word
   // Clock, reset and bus
   logic        ref_clk_i, rst_i;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   // Engine side
   cmf_pkg::cmf_engine_s       engine;
   logic                       abort_all_tx, module_enable, tx_load, xact_start, rx_req;
   logic [2:0]                 mode_status;
   cmf_pkg::cmf_filter_s [3:0] filter_cfg;
   logic [TW-1:0]              stamp;
   // Bookkeeping
   int          miscompares, num_checks;
   logic [31:0] rng_q = 32'h567B_B2D9;          // Random state
   logic [31:0] exp_q[$], msk_q[$];             // Expected read data and mask
   logic [1:0]  rsp_q[$], bsp_q[$];             // Expected responses
   logic [2:0]  seq[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5, 3'h6, 3'h4};

   cmf_core #(.TMR_W(TW)) DUT (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .engine_i(engine), .abort_all_tx_o(abort_all_tx), .module_enable_o(module_enable),
      .mode_status_o(mode_status), .filter_cfg_o(filter_cfg), .rx_timestamp_o(stamp));

   cmf_eng_model ENG (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .abort_all_tx_i(abort_all_tx),
      .module_enable_i(module_enable), .tx_load_i(tx_load), .xact_start_i(xact_start),
      .rx_req_i(rx_req), .engine_o(engine));

   // 50 MHz clock
   initial
   begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Write: address and data offered together, bready held until the answer
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      bsp_q.push_back(r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge ref_clk_i);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   // Read: the monitor compares the data against the noted mask and value
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] r);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      rsp_q.push_back(r);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge ref_clk_i);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // One reception seen by the engine, then two cycles to settle
   task automatic pulse_rx();
      rx_req <= 1'b1;
      @(posedge ref_clk_i);
      rx_req <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
   endtask

   task automatic print_verdict();
      $display("num_checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Monitor: oldest note against each answer taken
   always @(posedge ref_clk_i)
   begin
      if (s_axi_rvalid && s_axi_rready && rsp_q.size() > 0)
      begin
         chk(s_axi_rdata & msk_q.pop_front(), exp_q.pop_front());
         chk(32'(s_axi_rresp), 32'(rsp_q.pop_front()));
      end
      if (s_axi_bvalid && s_axi_bready && bsp_q.size() > 0)
         chk(32'(s_axi_bresp), 32'(bsp_q.pop_front()));
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      miscompares++;
      print_verdict();
   end

   initial
   begin
      logic [31:0] f, r;
      logic [2:0]  prev, e;
      int          i;
      rst_i = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {tx_load, xact_start, rx_req} = '0;
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      rd(12'h000, 32'h0480_0000, ALL, 2'h0);
      chk(32'(mode_status), 32'h4);
      rd(12'h004, 32'h0, ALL, 2'h0);
      // Every mode code, reserved ones last but one
      prev = 3'h4;
      for (i = 0; i < 8; i++)
      begin
         e = (seq[i] == 3'h5 || seq[i] == 3'h6) ? prev : seq[i];
         wr(12'h000, {5'h00, seq[i], 24'h0}, 2'h0);
         repeat (2) @(posedge ref_clk_i);
         chk(32'(mode_status), 32'(prev));
         repeat (6) @(posedge ref_clk_i);
         rd(12'h000, {5'h00, e, e, 21'h0}, MCM, 2'h0);
         prev = e;
      end
      // Abort with a frame pending
      tx_load <= 1'b1;
      @(posedge ref_clk_i);
      tx_load <= 1'b0;
      wr(12'h000, 32'h0C00_0000, 2'h0);
      rd(12'h000, 32'h0800_0000, 32'h0800_0000, 2'h0);
      chk(32'(abort_all_tx), 32'h1);
      for (i = 0; i < 100 && engine.tx_pending; i++) @(posedge ref_clk_i);
      repeat (2) @(posedge ref_clk_i);
      rd(12'h000, 32'h0, 32'h0800_0000, 2'h0);
      chk(32'(abort_all_tx), 32'h0);
      // Switch off while a frame runs
      wr(12'h000, 32'h0400_8000, 2'h0);
      chk(32'(module_enable), 32'h1);
      xact_start <= 1'b1;
      @(posedge ref_clk_i);
      xact_start <= 1'b0;
      wr(12'h000, 32'h0400_0000, 2'h0);
      chk(32'(module_enable), 32'h0);
      rd(12'h000, 32'h0000_0800, 32'h0000_0800, 2'h0);
      for (i = 0; i < 100 && engine.xact_active; i++) @(posedge ref_clk_i);
      repeat (2) @(posedge ref_clk_i);
      rd(12'h000, 32'h0, 32'h0000_0800, 2'h0);
      // Time stamps
      pulse_rx();
      rd(12'h008, 32'h0, ALL, 2'h0);
      wr(12'h000, 32'h0410_0000, 2'h0);
      pulse_rx();
      f = 32'(stamp);
      chk(32'(stamp != '0), 32'h1);
      repeat (4) @(posedge ref_clk_i);
      pulse_rx();
      chk(32'(stamp - f[TW-1:0]), 32'h7);
      wr(12'h000, 32'h0400_0000, 2'h0);
      f = 32'(stamp);
      pulse_rx();
      chk(32'(stamp), f);
      // Filter fields while disabled, extreme codes first
      for (i = 0; i < 3; i++)
      begin
         rng_q = xs(rng_q);
         f = (i == 0) ? 32'h7F7F_0000 : rng_q & 32'h7F7F_7F7F;
         wr(12'h004, f, 2'h0);
         rd(12'h004, f, ALL, 2'h0);
         chk(32'(filter_cfg[3]), 32'(f[31:24]));
         chk(32'(filter_cfg[2]), 32'(f[23:16]));
      end
      f = f | 32'h8080_8080;
      wr(12'h004, f, 2'h0);
      rd(12'h004, f, ALL, 2'h0);
      rng_q = xs(rng_q);
      r = rng_q;
      wr(12'h004, r, 2'h0);
      f = (f & 32'h7F7F_7F7F) | (r & 32'h8080_8080);
      rd(12'h004, f, ALL, 2'h0);
      chk(32'(filter_cfg[3]), 32'(f[31:24]));
      // Refused accesses
      rd(12'h00C, 32'h0, ALL, 2'h2);
      wr(12'h008, ALL, 2'h2);
      repeat (3) @(posedge ref_clk_i);
      print_verdict();
   end
endmodule
